// ===== core/i2c_register_access_slave.sv
`timescale 1ns/1ns
module i2c_register_access_slave #(
    parameter int REG_COUNT = i2c_slave_pkg::REG_COUNT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic regWriteValid,
    output i2c_slave_pkg::reg_write_t regWrite
);

    initial begin
        if (REG_COUNT < 1 || REG_COUNT > (1 << i2c_slave_pkg::MEM_ADDR_W)) begin
            $error("i2c_register_access_slave: REG_COUNT out of range");
        end
    end

    localparam logic [i2c_slave_pkg::PTR_W-1:0] REG_LIMIT = i2c_slave_pkg::PTR_W'(REG_COUNT);

    logic sclMetaReg, sclSyncReg, sclPrevReg;
    logic sdaMetaReg, sdaSyncReg, sdaPrevReg;
    i2c_slave_pkg::slave_state_t stateReg, stateNext;
    i2c_slave_pkg::slave_state_t afterAckReg, afterAckNext;
    logic [2:0] bitCntReg, bitCntNext;
    logic [7:0] rxShiftReg, rxShiftNext;
    logic [7:0] txShiftReg, txShiftNext;
    logic [8:0] ptrReg, ptrNext;
    logic presetReg, presetNext;
    logic startHighReg, startHighNext;
    logic ackOnReg, ackOnNext;
    logic sdaOeNNext;
    logic regWriteValidNext;
    i2c_slave_pkg::reg_write_t regWriteNext;
    logic [7:0] memRdData;

    // Pins pass two sync flops and a third for edges; the second and third stages feed the detectors
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclMetaReg <= 1'b1;
            sclSyncReg <= 1'b1;
            sclPrevReg <= 1'b1;
            sdaMetaReg <= 1'b1;
            sdaSyncReg <= 1'b1;
            sdaPrevReg <= 1'b1;
        end else begin
            sclMetaReg <= scl;
            sclSyncReg <= sclMetaReg;
            sclPrevReg <= sclSyncReg;
            sdaMetaReg <= sdaIn;
            sdaSyncReg <= sdaMetaReg;
            sdaPrevReg <= sdaSyncReg;
        end
    end

    wire sclRise = sclSyncReg && !sclPrevReg;
    wire sclFall = !sclSyncReg && sclPrevReg;
    wire sclHeld = sclSyncReg && sclPrevReg;
    wire startCond = sclHeld && sdaPrevReg && !sdaSyncReg;
    wire stopCond = sclHeld && !sdaPrevReg && sdaSyncReg;
    wire stopTaken = stopCond && !startHighReg;
    wire [7:0] rxByte = {rxShiftReg[6:0], sdaSyncReg};
    wire receiving = stateReg == i2c_slave_pkg::ADDR || stateReg == i2c_slave_pkg::PTR ||
                     stateReg == i2c_slave_pkg::WDATA;
    wire byteDone = receiving && sclRise && bitCntReg == i2c_slave_pkg::BIT_LAST;
    wire addrMatch = rxByte[7:1] == i2c_slave_pkg::SLAVE_ADDR7;
    wire addrRead = rxByte[0] == i2c_slave_pkg::DIR_READ;
    wire ptrInRange = ptrReg < REG_LIMIT;
    // Saturating at one past the top keeps every later byte on the fill value
    wire [8:0] ptrInc = ptrReg[8] ? ptrReg : ptrReg + i2c_slave_pkg::PTR_STEP;
    wire [7:0] readByte = ptrInRange ? memRdData : i2c_slave_pkg::FILL_BYTE;
    wire memWrEn = regWriteValidNext;

    always_comb begin
        stateNext = stateReg;
        afterAckNext = afterAckReg;
        bitCntNext = bitCntReg;
        rxShiftNext = rxShiftReg;
        txShiftNext = txShiftReg;
        ptrNext = ptrReg;
        presetNext = presetReg;
        startHighNext = startHighReg;
        ackOnNext = ackOnReg;
        sdaOeNNext = sdaOeN;
        regWriteValidNext = 1'b0;
        regWriteNext = regWrite;
        if (sclFall) begin
            startHighNext = 1'b0;
        end
        if (startCond) begin
            stateNext = i2c_slave_pkg::ADDR;
            bitCntNext = i2c_slave_pkg::BIT_FIRST;
            sdaOeNNext = 1'b1;
            ackOnNext = 1'b0;
            startHighNext = 1'b1;
        end else if (stopTaken) begin
            stateNext = i2c_slave_pkg::IDLE;
            sdaOeNNext = 1'b1;
            ackOnNext = 1'b0;
            presetNext = 1'b0;
        end else begin
            case (stateReg)
                i2c_slave_pkg::ADDR, i2c_slave_pkg::PTR, i2c_slave_pkg::WDATA: begin
                    if (sclRise) begin
                        rxShiftNext = rxByte;
                        bitCntNext = bitCntReg + i2c_slave_pkg::BIT_STEP;
                    end
                    if (byteDone) begin
                        stateNext = i2c_slave_pkg::ACK;
                        afterAckNext = i2c_slave_pkg::WDATA;
                        if (stateReg == i2c_slave_pkg::ADDR) begin
                            if (!addrMatch) begin
                                stateNext = i2c_slave_pkg::IDLE;
                            end else if (addrRead) begin
                                afterAckNext = i2c_slave_pkg::RDATA;
                                if (!presetReg) begin
                                    ptrNext = i2c_slave_pkg::PTR_FIRST;
                                end
                            end else begin
                                afterAckNext = i2c_slave_pkg::PTR;
                            end
                        end else if (stateReg == i2c_slave_pkg::PTR) begin
                            ptrNext = {1'b0, rxByte};
                            presetNext = 1'b1;
                        end else begin
                            regWriteValidNext = ptrInRange;
                            regWriteNext.addr = ptrReg[7:0];
                            regWriteNext.data = rxByte;
                            ptrNext = ptrInc;
                        end
                    end
                end
                i2c_slave_pkg::ACK: begin
                    if (sclFall && !ackOnReg) begin
                        sdaOeNNext = 1'b0;
                        ackOnNext = 1'b1;
                    end else if (sclFall) begin
                        ackOnNext = 1'b0;
                        bitCntNext = i2c_slave_pkg::BIT_FIRST;
                        sdaOeNNext = 1'b1;
                        stateNext = afterAckReg;
                        if (afterAckReg == i2c_slave_pkg::RDATA) begin
                            sdaOeNNext = readByte[7];
                            txShiftNext = {readByte[6:0], 1'b0};
                            bitCntNext = i2c_slave_pkg::BIT_STEP;
                        end
                    end
                end
                i2c_slave_pkg::RDATA: begin
                    // Eight bits driven once the counter wraps back to zero
                    if (sclFall && bitCntReg == i2c_slave_pkg::BIT_FIRST) begin
                        sdaOeNNext = 1'b1;
                        stateNext = i2c_slave_pkg::RMACK;
                    end else if (sclFall) begin
                        sdaOeNNext = txShiftReg[7];
                        txShiftNext = {txShiftReg[6:0], 1'b0};
                        bitCntNext = bitCntReg + i2c_slave_pkg::BIT_STEP;
                    end
                end
                i2c_slave_pkg::RMACK: begin
                    if (sclRise) begin
                        ptrNext = ptrInc;
                        stateNext = sdaSyncReg ? i2c_slave_pkg::WAITSTOP : i2c_slave_pkg::RNEXT;
                    end
                end
                i2c_slave_pkg::RNEXT: begin
                    if (sclFall) begin
                        sdaOeNNext = readByte[7];
                        txShiftNext = {readByte[6:0], 1'b0};
                        bitCntNext = i2c_slave_pkg::BIT_STEP;
                        stateNext = i2c_slave_pkg::RDATA;
                    end
                end
                default: begin
                    sdaOeNNext = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= i2c_slave_pkg::IDLE;
            afterAckReg <= i2c_slave_pkg::PTR;
            bitCntReg <= i2c_slave_pkg::BIT_FIRST;
            rxShiftReg <= i2c_slave_pkg::REG_RESET;
            txShiftReg <= i2c_slave_pkg::REG_RESET;
            ptrReg <= i2c_slave_pkg::PTR_FIRST;
        end else begin
            stateReg <= stateNext;
            afterAckReg <= afterAckNext;
            bitCntReg <= bitCntNext;
            rxShiftReg <= rxShiftNext;
            txShiftReg <= txShiftNext;
            ptrReg <= ptrNext;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presetReg <= 1'b0;
            startHighReg <= 1'b0;
            ackOnReg <= 1'b0;
            sdaOeN <= 1'b1;
            sdaOut <= 1'b0;
            regWriteValid <= 1'b0;
            regWrite <= '0;
        end else begin
            presetReg <= presetNext;
            startHighReg <= startHighNext;
            ackOnReg <= ackOnNext;
            sdaOeN <= sdaOeNNext;
            sdaOut <= 1'b0;
            regWriteValid <= regWriteValidNext;
            regWrite <= regWriteNext;
        end
    end

    // Read port follows the pointer one clock behind, well inside an SCL high phase
    reg_store #(
        .DATA_W(i2c_slave_pkg::DATA_W),
        .ADDR_W(i2c_slave_pkg::MEM_ADDR_W),
        .DEPTH(REG_COUNT)
    ) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(memWrEn),
        .wrAddr(regWriteNext.addr),
        .wrData(regWriteNext.data),
        .rdAddr(ptrReg[7:0]),
        .rdData(memRdData)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_read_addr;
        stateReg == i2c_slave_pkg::ADDR && byteDone && addrMatch && addrRead;
    endsequence

    sequence s_master_nack;
        stateReg == i2c_slave_pkg::RMACK && sclRise && sdaSyncReg && !startCond && !stopCond;
    endsequence

    a_stop_ends_frame: assert property (stopTaken |=> stateReg == i2c_slave_pkg::IDLE && sdaOeN)
        else $error("STOP did not end the frame");

    a_stop_same_high: assert property (stopCond && startHighReg && !startCond |=> $stable(stateReg))
        else $error("STOP in the START high period was taken");

    a_ack_held_low: assert property ($rose(ackOnReg) |-> !sdaOeN until_with (sclFall || startCond || stopCond))
        else $error("Acknowledge released before the ninth pulse ended");

    a_ptr_load: assert property (stateReg == i2c_slave_pkg::PTR && byteDone && !startCond && !stopCond
        |=> ptrReg == {1'b0, $past(rxByte)} && presetReg)
        else $error("Pointer byte not loaded");

    a_write_store: assert property (regWriteValid |-> $past(ptrReg) == {1'b0, regWrite.addr}
        && ptrReg == $past(ptrReg) + i2c_slave_pkg::PTR_STEP)
        else $error("Write not stored at pointer or pointer not advanced");

    a_read_restart: assert property (s_read_addr and (!presetReg && !startCond && !stopCond)
        |=> ptrReg == i2c_slave_pkg::PTR_FIRST)
        else $error("Read frame did not restart at the first register");

    a_preset_kept: assert property (s_read_addr and (presetReg && !startCond && !stopCond) |=> $stable(ptrReg))
        else $error("Preset pointer lost on repeated START read");

    a_read_advance: assert property (stateReg == i2c_slave_pkg::RMACK && sclRise && !startCond && !stopCond
        && !ptrReg[8] |=> ptrReg == $past(ptrReg) + i2c_slave_pkg::PTR_STEP)
        else $error("Pointer did not advance after a read byte");

    // Watches the wire and the shifter, not the select that feeds them
    a_fill_past_end: assert property (stateReg == i2c_slave_pkg::RNEXT && sclFall && !ptrInRange
        && !startCond && !stopCond
        |=> sdaOeN == i2c_slave_pkg::FILL_BYTE[7] && txShiftReg == {i2c_slave_pkg::FILL_BYTE[6:0], 1'b0})
        else $error("Out of range read not filled");

    a_reserved_safe: assert property (regWriteValid |-> {1'b0, regWrite.addr} < REG_LIMIT)
        else $error("Write reached a reserved location");

    a_drive_on_low: assert property ($changed(sdaOeN) |-> $past(sclFall) || $past(startCond) || $past(stopCond))
        else $error("SDA drive changed outside SCL low");

    a_bad_addr: assert property (stateReg == i2c_slave_pkg::ADDR && byteDone && !addrMatch && !startCond
        && !stopCond |=> stateReg == i2c_slave_pkg::IDLE [*2])
        else $error("Foreign address answered");

    a_nack_release: assert property (s_master_nack |=> stateReg == i2c_slave_pkg::WAITSTOP && sdaOeN)
        else $error("SDA not released after NACK");

endmodule : i2c_register_access_slave

// ===== core/i2c_slave_pkg.sv
package i2c_slave_pkg;

    // Seven-bit bus address; the eighth bit on the wire is the direction
    localparam logic [6:0] SLAVE_ADDR7 = 7'h44;
    localparam logic DIR_READ = 1'b1;

    localparam int DATA_W = 8;
    localparam int PTR_W = 9;
    localparam int MEM_ADDR_W = 8;

    // First reserved location; everything from here up reads as the fill byte
    localparam int REG_COUNT = 246;
    localparam logic [PTR_W-1:0] PTR_FIRST = 9'h000;
    localparam logic [PTR_W-1:0] PTR_STEP = 9'h001;
    localparam logic [DATA_W-1:0] FILL_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    typedef enum logic [3:0] {
        IDLE,
        ADDR,
        PTR,
        WDATA,
        ACK,
        RDATA,
        RMACK,
        RNEXT,
        WAITSTOP
    } slave_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } reg_write_t;

endpackage : i2c_slave_pkg

// ===== core/reg_store.sv
`timescale 1ns/1ns
module reg_store #(
    parameter int DATA_W = i2c_slave_pkg::DATA_W,
    parameter int ADDR_W = i2c_slave_pkg::MEM_ADDR_W,
    parameter int DEPTH = i2c_slave_pkg::REG_COUNT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData
);

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin
            $error("reg_store: DEPTH does not fit the address width");
        end
    end

    logic [DATA_W-1:0] entry [DEPTH];

    // Flops rather than a RAM so every register has a known value after reset
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    entry[i] <= i2c_slave_pkg::REG_RESET;
                end else if (wrEn && wrAddr == ADDR_W'(i)) begin
                    entry[i] <= wrData;
                end
            end
        end
    endgenerate

    wire rdInRange = int'(rdAddr) < DEPTH;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= i2c_slave_pkg::REG_RESET;
        end else begin
            rdData <= rdInRange ? entry[rdAddr] : i2c_slave_pkg::REG_RESET;
        end
    end

endmodule : reg_store

// ===== tb/i2c_bus_master.sv
`timescale 1ns/1ns
module i2c_bus_master (
    input wire logic clk,
    input wire logic sdaW,
    output logic scl,
    output logic sdaM,
    output int unstable
);
    initial begin
        scl = 1'b1;
        sdaM = 1'b1;
        unstable = 0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    // Data moves only while the clock is low
    task automatic bitx(input logic b, output logic r);
        wt(2);
        sdaM = b;
        wt(2);
        scl = 1'b1;
        r = sdaW;
        wt(4);
        // Wire must hold its level for the whole high phase
        if (sdaW !== r) unstable++;
        scl = 1'b0;
    endtask : bitx

    // No STOP follows START in its high phase; after stop() the START shares the STOP's high phase
    task automatic start();
        wt(4);
        sdaM = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(2);
        sdaM = 1'b0;
        wt(2);
        scl = 1'b0;
    endtask : start

    // Breaks on purpose: STOP inside the high phase of its own START
    task automatic start_stop();
        wt(4);
        sdaM = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(2);
        sdaM = 1'b0;
        wt(2);
        sdaM = 1'b1;
        wt(2);
        scl = 1'b0;
    endtask : start_stop

    task automatic stop();
        wt(4);
        sdaM = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(2);
        sdaM = 1'b1;
        wt(4);
    endtask : stop

    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, ack);
    endtask : tx

    // Master acks the byte, or sends a NACK when nack is set
    task automatic rx(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask : rx
endmodule : i2c_bus_master

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic sdaM;
    logic sdaW;
    logic sdaOut;
    logic sdaOeN;
    logic regWriteValid;
    i2c_slave_pkg::reg_write_t regWrite;
    i2c_slave_pkg::reg_write_t wq[$];
    logic [7:0] bq[$];
    int unstable;
    int fails = 0;
    int num_checks = 0;

    always #25 clk = ~clk;
    // Pull-up wins unless a party pulls low
    assign sdaW = sdaM & (sdaOeN | sdaOut);
    // Sampled on the falling edge, clear of the edge that launches the pulse
    always @(negedge clk) if (regWriteValid === 1'b1) wq.push_back(regWrite);

    i2c_register_access_slave i_i2c_register_access_slave (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaW),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .regWriteValid(regWriteValid), .regWrite(regWrite));
    i2c_bus_master i_i2c_bus_master (.clk(clk), .sdaW(sdaW), .scl(scl), .sdaM(sdaM), .unstable(unstable));

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : chk

    task automatic chkw(input logic [7:0] a, input logic [7:0] d);
        i2c_slave_pkg::reg_write_t w;
        w = '0;
        if (wq.size() != 0) w = wq.pop_front();
        chk(w.addr, a, "write address");
        chk(w.data, d, "write data");
    endtask : chkw

    task automatic chknone();
        chk(8'(wq.size()), 8'h00, "unexpected register write");
    endtask : chknone

    task automatic wr(input logic [7:0] ptr);
        logic a;
        i_i2c_bus_master.start();
        i_i2c_bus_master.tx(8'h88, a);
        chk({7'h00, a}, 8'h00, "write address ack");
        i_i2c_bus_master.tx(ptr, a);
        chk({7'h00, a}, 8'h00, "pointer ack");
        foreach (bq[i]) begin
            i_i2c_bus_master.tx(bq[i], a);
            chk({7'h00, a}, 8'h00, "data ack");
        end
        i_i2c_bus_master.stop();
    endtask : wr

    task automatic rd(input logic preset, input logic [7:0] ptr);
        logic a;
        logic [7:0] d;
        if (preset) begin
            i_i2c_bus_master.start();
            i_i2c_bus_master.tx(8'h88, a);
            i_i2c_bus_master.tx(ptr, a);
        end
        i_i2c_bus_master.start();
        i_i2c_bus_master.tx(8'h89, a);
        chk({7'h00, a}, 8'h00, "read address ack");
        foreach (bq[i]) begin
            i_i2c_bus_master.rx(i == bq.size() - 1, d);
            chk(d, bq[i], "read byte");
        end
        i_i2c_bus_master.stop();
    endtask : rd

    task automatic t_write_read();
        bq = '{8'h11, 8'h22, 8'h33};
        wr(8'h00);
        chkw(8'h00, 8'h11);
        chkw(8'h01, 8'h22);
        chkw(8'h02, 8'h33);
        rd(1'b0, 8'h00);
        bq = '{8'h11};
        rd(1'b0, 8'h00);
        $display("test write_read done");
    endtask : t_write_read

    task automatic t_preset();
        bq = '{8'h5A};
        wr(8'h10);
        chkw(8'h10, 8'h5A);
        bq = '{8'h5A, 8'h00};
        rd(1'b1, 8'h10);
        bq = '{8'h11};
        rd(1'b0, 8'h00);
        $display("test preset done");
    endtask : t_preset

    task automatic t_top();
        bq = '{8'h77, 8'h88};
        wr(8'hF5);
        chkw(8'hF5, 8'h77);
        chknone();
        bq = '{8'h77};
        repeat (11) bq.push_back(8'hFF);
        rd(1'b1, 8'hF5);
        $display("test top done");
    endtask : t_top

    task automatic t_foreign();
        logic a;
        logic [7:0] addrs[3];
        addrs = '{8'h08, 8'h98, 8'h8A};
        foreach (addrs[i]) begin
            i_i2c_bus_master.start();
            i_i2c_bus_master.tx(addrs[i], a);
            chk({7'h00, a}, 8'h01, "foreign address ack");
            i_i2c_bus_master.stop();
        end
        chknone();
        $display("test foreign done");
    endtask : t_foreign

    task automatic t_nack_release();
        logic a;
        logic [7:0] d;
        i_i2c_bus_master.start();
        i_i2c_bus_master.tx(8'h89, a);
        i_i2c_bus_master.rx(1'b1, d);
        chk(d, 8'h11, "first read byte");
        i_i2c_bus_master.rx(1'b1, d);
        chk(d, 8'hFF, "bus released after nack");
        i_i2c_bus_master.stop();
        $display("test nack_release done");
    endtask : t_nack_release

    // A byte clocked after an early STOP, with no new START, must be ignored
    task automatic t_early_stop();
        logic a;
        i_i2c_bus_master.start();
        i_i2c_bus_master.tx(8'h88, a);
        i_i2c_bus_master.tx(8'h20, a);
        repeat (3) i_i2c_bus_master.bitx(1'b0, a);
        i_i2c_bus_master.stop();
        i_i2c_bus_master.tx(8'h5A, a);
        chk({7'h00, a}, 8'h01, "byte after stop acked");
        i_i2c_bus_master.stop();
        chknone();
        $display("test early_stop done");
    endtask : t_early_stop

    // A STOP in the START high phase must leave the frame running
    task automatic t_same_high();
        logic a;
        i_i2c_bus_master.start_stop();
        i_i2c_bus_master.tx(8'h88, a);
        chk({7'h00, a}, 8'h00, "address ack after ignored stop");
        i_i2c_bus_master.tx(8'h30, a);
        i_i2c_bus_master.tx(8'h42, a);
        i_i2c_bus_master.stop();
        chkw(8'h30, 8'h42);
        $display("test same_high done");
    endtask : t_same_high

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Run needs about 0.21 ms; allow a wide margin
    initial begin
        #1000000;
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_write_read();
        t_preset();
        t_top();
        t_foreign();
        t_nack_release();
        t_early_stop();
        t_same_high();
        chk(8'(unstable), 8'h00, "sda moved while scl high");
        give_verdict();
    end
endmodule : tb_top
